// ==== hw/isrp_pkg.sv ====
// constants and types shared by the i2c slave register port
package isrp_pkg;

    // bus address of the slave, upper seven bits of the address byte
    localparam logic [6:0] I2C_SLV_ADDR    = 7'h25;
    localparam int         FSCL_MAX_KHZ    = 400;     // fastest serial clock the port follows
    localparam int         LCLK_PERIOD_NS  = 64;      // link sampling clock period
    localparam int         SPIKE_MAX_NS    = 50;      // widest spike that must be rejected
    localparam int         SETUP_MIN_NS    = 1250;    // data ahead of clock release when stretching
    // a level is accepted once it has stood longer than the widest spike
    localparam int         FILT_CYC        = SPIKE_MAX_NS / LCLK_PERIOD_NS + 1;
    // least time rounds up to whole link cycles
    localparam int         STRETCH_CYC     = (SETUP_MIN_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;
    localparam logic [2:0] FILT_LAST       = 3'(FILT_CYC);
    localparam logic [5:0] STRETCH_LAST    = 6'(STRETCH_CYC - 1);
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0] LAST_BIT        = 4'h7;
    localparam int         REG_AW          = 5;       // register file holds 32 bytes
    localparam int         REG_DEPTH       = 32;

    // request handed from the link domain to the core domain
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } isrp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_WAIT,
        ST_FETCH,
        ST_SETUP,
        ST_TX,
        ST_RACK
    } isrp_state_t;

    typedef enum logic [1:0] {
        PH_ADDR,
        PH_PTR,
        PH_DATA
    } isrp_phase_t;

endpackage : isrp_pkg

// ==== hw/isrp_regmem.sv ====
// register storage: host port with registered read data, core write port
`timescale 1ns/1ps
module isrp_regmem
    import isrp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              a_en,
    input  wire logic              a_we,
    input  wire logic [REG_AW-1:0] a_addr,
    input  wire logic [7:0]        a_wdata,
    output logic      [7:0]        a_rdata,
    input  wire logic              b_we,
    input  wire logic [REG_AW-1:0] b_addr,
    input  wire logic [7:0]        b_wdata
);

    logic [7:0] mem [REG_DEPTH];

    // one writer for the array; the host write wins a same-cycle collision
    always_ff @(posedge clk) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_wdata;
        end else if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
    end

    // read data leaves through a register
    always_ff @(posedge clk) begin
        if (a_en) begin
            a_rdata <= mem[a_addr];
        end
    end

endmodule : isrp_regmem

// ==== hw/isrp_top.sv ====
// i2c slave port: filtered link front end, byte engine, crossing to register storage
// Notes on behaviour
// - follow serial clock from zero to 400 kHz
// - reject line spikes up to 50 ns
// - bare read starts at current pointer
// - data stands 1250 ns before a stretched clock is released
`timescale 1ns/1ps
module isrp_top
    import isrp_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        LCLK,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    input  wire logic        STAT_WE,
    input  wire logic [4:0]  STAT_ADDR,
    input  wire logic [7:0]  STAT_WDATA,
    output logic             CFG_WE,
    output logic [7:0]       CFG_ADDR,
    output logic [7:0]       CFG_WDATA
);

    // ---------------- link domain ----------------
    logic        lrst_s1_r;
    logic        lrst_s2_r;
    logic        lrst;
    logic [1:0]  pin_raw;
    logic [1:0]  pin_flt;
    logic        scl_f;
    logic        sda_f;
    logic        scl_prev_r;
    logic        sda_prev_r;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    isrp_state_t state_r;
    isrp_state_t after_r;
    isrp_phase_t phase_r;
    logic [3:0]  bit_cnt_r;
    logic [5:0]  stretch_cnt_r;
    logic [7:0]  shreg_r;
    logic [7:0]  ptr_r;
    logic        rw_r;
    logic        nack_r;
    isrp_req_t   req_r;
    logic        req_tgl_r;
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic        ack_s3_r;
    logic        ack_evt;

    // ---------------- core domain ----------------
    logic        req_s1_r;
    logic        req_s2_r;
    logic        req_s3_r;
    logic        req_evt;
    logic        rsp_pend_r;
    logic [7:0]  rsp_r;
    logic        ack_tgl_r;
    logic [7:0]  mem_rdata;

    // core reset brought onto the link clock
    always_ff @(posedge LCLK) begin
        lrst_s1_r <= NRST;
        lrst_s2_r <= lrst_s1_r;
    end
    assign lrst = ~lrst_s2_r;

    assign pin_raw = {SDA_I, SCL_I};

    // per line: two-stage synchroniser, then a level must hold before it is taken
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic       s1_r;
        logic       s2_r;
        logic       flt_r;
        logic [2:0] cnt_r;
        always_ff @(posedge LCLK) begin
            s1_r <= pin_raw[g];
            s2_r <= s1_r;
        end
        // a differing level must stand for more than the spike width
        always_ff @(posedge LCLK) begin
            if (lrst) begin
                flt_r <= 1'b1;
                cnt_r <= '0;
            end else if (s2_r == flt_r) begin
                cnt_r <= '0;
            end else if (cnt_r == FILT_LAST) begin
                flt_r <= s2_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 3'd1;
            end
        end
        assign pin_flt[g] = flt_r;
    end

    assign scl_f = pin_flt[0];
    assign sda_f = pin_flt[1];

    // previous filtered levels for edge and condition detection
    always_ff @(posedge LCLK) begin
        if (lrst) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_f;
            sda_prev_r <= sda_f;
        end
    end

    // edges are event driven, so any clock rate up to the fast-mode ceiling works
    assign scl_rise  = scl_f & ~scl_prev_r;
    assign scl_fall  = ~scl_f & scl_prev_r;
    assign start_det = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
    assign stop_det  = scl_f & scl_prev_r & ~sda_prev_r & sda_f;

    // answer toggle from the core domain
    always_ff @(posedge LCLK) begin
        if (lrst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end
    assign ack_evt = ack_s2_r ^ ack_s3_r;

    // byte engine: address, pointer, data, acknowledge, stretch and transmit
    always_ff @(posedge LCLK) begin
        if (lrst) begin
            state_r       <= ST_IDLE;
            after_r       <= ST_IDLE;
            phase_r       <= PH_ADDR;
            bit_cnt_r     <= '0;
            stretch_cnt_r <= '0;
            shreg_r       <= '0;
            ptr_r         <= '0;
            rw_r          <= 1'b0;
            nack_r        <= 1'b0;
            req_r         <= '0;
            req_tgl_r     <= 1'b0;
            SDA_OE        <= 1'b0;
            SCL_OE        <= 1'b0;
        end else if (start_det) begin
            state_r   <= ST_RX;
            phase_r   <= PH_ADDR;
            bit_cnt_r <= '0;
            SDA_OE    <= 1'b0;
            SCL_OE    <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            SDA_OE  <= 1'b0;
            SCL_OE  <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    SDA_OE <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shreg_r   <= {shreg_r[6:0], sda_f};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                    end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                        bit_cnt_r <= '0;
                        unique case (phase_r)
                            PH_ADDR: begin
                                if (shreg_r[7:1] == I2C_SLV_ADDR) begin
                                    rw_r    <= shreg_r[0];
                                    SDA_OE  <= 1'b1;
                                    state_r <= ST_ACK;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end
                            PH_PTR: begin
                                ptr_r   <= shreg_r;
                                phase_r <= PH_DATA;
                                SDA_OE  <= 1'b1;
                                state_r <= ST_ACK;
                            end
                            PH_DATA: begin
                                req_r     <= '{we: 1'b1, addr: ptr_r, wdata: shreg_r};
                                req_tgl_r <= ~req_tgl_r;
                                ptr_r     <= ptr_r + 8'd1;
                                SDA_OE    <= 1'b1;
                                SCL_OE    <= 1'b1; // hold clock until the write lands
                                state_r   <= ST_WAIT;
                            end
                        endcase
                    end
                end
                ST_WAIT: begin
                    if (ack_evt) begin
                        stretch_cnt_r <= '0;
                        after_r       <= ST_ACK;
                        state_r       <= ST_SETUP;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        SDA_OE <= 1'b0;
                        if (phase_r == PH_ADDR && rw_r) begin
                            // read with no pointer byte uses the pointer as it stands
                            req_r     <= '{we: 1'b0, addr: ptr_r, wdata: 8'h00};
                            req_tgl_r <= ~req_tgl_r;
                            SCL_OE    <= 1'b1;
                            state_r   <= ST_FETCH;
                        end else begin
                            if (phase_r == PH_ADDR) begin
                                phase_r <= PH_PTR;
                            end
                            state_r <= ST_RX;
                        end
                    end
                end
                ST_FETCH: begin
                    if (ack_evt) begin
                        shreg_r       <= rsp_r;
                        SDA_OE        <= ~rsp_r[7]; // first bit goes out while clock is held
                        ptr_r         <= ptr_r + 8'd1;
                        bit_cnt_r     <= '0;
                        stretch_cnt_r <= '0;
                        after_r       <= ST_TX;
                        state_r       <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // data is already on the line; count out the setup before letting go
                    if (stretch_cnt_r == STRETCH_LAST) begin
                        SCL_OE  <= 1'b0;
                        state_r <= after_r;
                    end else begin
                        stretch_cnt_r <= stretch_cnt_r + 6'd1;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == LAST_BIT) begin
                            SDA_OE  <= 1'b0;
                            state_r <= ST_RACK;
                        end else begin
                            SDA_OE    <= ~shreg_r[6];
                            shreg_r   <= {shreg_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'd1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_r <= sda_f;
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            req_r     <= '{we: 1'b0, addr: ptr_r, wdata: 8'h00};
                            req_tgl_r <= ~req_tgl_r;
                            SCL_OE    <= 1'b1;
                            state_r   <= ST_FETCH;
                        end
                    end
                end
            endcase
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge LCLK) begin
        SCL_O <= 1'b0;
        SDA_O <= 1'b0;
    end

    // request toggle brought onto the core clock
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end
    assign req_evt = req_s2_r ^ req_s3_r;

    // access result returned one cycle after the request, then the answer toggles
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rsp_pend_r <= 1'b0;
            rsp_r      <= '0;
            ack_tgl_r  <= 1'b0;
        end else begin
            rsp_pend_r <= req_evt;
            if (rsp_pend_r) begin
                rsp_r     <= mem_rdata;
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    // host writes announced to the core as a one-cycle strobe
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            CFG_WE    <= 1'b0;
            CFG_ADDR  <= '0;
            CFG_WDATA <= '0;
        end else begin
            CFG_WE <= req_evt & req_r.we;
            // read fetches leave the last write's fields standing
            if (req_evt && req_r.we) begin
                CFG_ADDR  <= req_r.addr;
                CFG_WDATA <= req_r.wdata;
            end
        end
    end

    // storage; pointer wraps into the 32-byte window
    isrp_regmem u_mem (
        .clk     (CLK),
        .a_en    (req_evt),
        .a_we    (req_r.we),
        .a_addr  (req_r.addr[REG_AW-1:0]),
        .a_wdata (req_r.wdata),
        .a_rdata (mem_rdata),
        .b_we    (STAT_WE),
        .b_addr  (STAT_ADDR),
        .b_wdata (STAT_WDATA)
    );

endmodule : isrp_top

// ==== tb/isrp_monitor.sv ====
// concurrent checks on the slave port pins and the core write strobe
`timescale 1ns/1ps
module isrp_monitor
    import isrp_pkg::*;
(
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       LCLK,
    input wire logic       SCL_I,
    input wire logic       SCL_O,
    input wire logic       SCL_OE,
    input wire logic       SDA_O,
    input wire logic       SDA_OE,
    input wire logic       CFG_WE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA
);
    localparam int AGE_MIN = STRETCH_CYC - 1;
    logic [5:0] age_r;
    logic [7:0] hold_r;
    // link cycles since the data drive last changed
    always_ff @(posedge LCLK) begin
        if (!NRST || $changed(SDA_OE))
            age_r <= 6'h00;
        else if (age_r != 6'h3F)
            age_r <= age_r + 6'h01;
    end
    // length of the current clock stretch
    always_ff @(posedge LCLK) begin
        if (!NRST || !SCL_OE)
            hold_r <= 8'h00;
        else if (hold_r != 8'hFF)
            hold_r <= hold_r + 8'h01;
    end
    a_scl_open_drain: assert property (@(posedge LCLK) disable iff (!NRST) SCL_OE |-> !SCL_O)
        else $error("scl pulled high");
    a_sda_open_drain: assert property (@(posedge LCLK) disable iff (!NRST) SDA_OE |-> !SDA_O)
        else $error("sda pulled high");
    a_sda_moves_low: assert property (@(posedge LCLK) disable iff (!NRST) $changed(SDA_OE) |-> !SCL_I)
        else $error("sda drive changed while scl high");
    a_stretch_setup: assert property (@(posedge LCLK) disable iff (!NRST) $fell(SCL_OE) |-> age_r >= AGE_MIN)
        else $error("scl released too soon after data");
    a_stretch_bound: assert property (@(posedge LCLK) disable iff (!NRST) SCL_OE |-> hold_r < 8'hC8)
        else $error("clock stretch too long");
    a_scl_filtered: assert property (@(posedge LCLK) disable iff (!NRST)
        $rose(SCL_OE) |-> !$past(SCL_I) && !$past(SCL_I, 2) && !$past(SCL_I, 3))
        else $error("stretch on unfiltered clock fall");
    a_sda_filtered: assert property (@(posedge LCLK) disable iff (!NRST)
        $rose(SDA_OE) |-> !$past(SCL_I) && !$past(SCL_I, 2))
        else $error("drive on unfiltered clock fall");
    a_cfg_pulse: assert property (@(posedge CLK) disable iff (!NRST) CFG_WE |=> !CFG_WE)
        else $error("write strobe longer than one cycle");
    a_cfg_hold: assert property (@(posedge CLK) disable iff (!NRST)
        !CFG_WE |-> $stable(CFG_ADDR) && $stable(CFG_WDATA))
        else $error("write fields moved without strobe");
    c_stretch: cover property (@(posedge LCLK) disable iff (!NRST) $fell(SCL_OE));
    c_write: cover property (@(posedge CLK) disable iff (!NRST) CFG_WE);
    c_drive: cover property (@(posedge LCLK) disable iff (!NRST) $rose(SDA_OE));
endmodule : isrp_monitor

bind isrp_top isrp_monitor u_mon (.CLK(CLK), .NRST(NRST), .LCLK(LCLK), .SCL_I(SCL_I),
    .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CFG_WE(CFG_WE),
    .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA));

// ==== tb/isrp_host_mdl.sv ====
// bus master model driving the open-drain clock and data lines
`timescale 1ns/1ps
module isrp_host_mdl (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // release the clock and wait out a stretch, bounded
    task automatic rel_scl;
        scl_low = 1'b0;
        for (int i = 0; i < 3000 && !scl; i++)
            #10;
    endtask : rel_scl
    // 1300 ns low and 1200 ns high keep the rate at 400 kHz; spk adds 40 ns spikes
    task automatic hbit(input logic b, input logic spk, output logic r);
        sda_low = !b;
        #600;
        if (spk) begin
            scl_low = 1'b0;
            #40;
            scl_low = 1'b1;
        end
        #700;
        rel_scl();
        #600;
        r = sda;
        if (spk) begin
            sda_low = b;
            #40;
            sda_low = !b;
        end
        #600;
        scl_low = 1'b1;
    endtask : hbit
    task automatic wbyte(input logic [7:0] dt, input logic spk, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            hbit(dt[i], spk, r);
        hbit(1'b1, 1'b0, ack);
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] dt);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            hbit(1'b1, 1'b0, r);
            dt[i] = r;
        end
        hbit(nack, 1'b0, r);
    endtask : rbyte
    task automatic start;
        sda_low = 1'b0;
        #1300;
        rel_scl();
        #600;
        sda_low = 1'b1;
        #600;
        scl_low = 1'b1;
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        #1300;
        rel_scl();
        #600;
        sda_low = 1'b0;
        #1300;
    endtask : stop
endmodule : isrp_host_mdl

// ==== tb/tb.sv ====
// self-checking bench: random register traffic through the slave port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
    import isrp_pkg::*;
;
    logic       clk = 1'b0;
    logic       lclk = 1'b0;
    logic       nrst = 1'b0;
    logic       stat_we = 1'b0;
    logic [4:0] stat_addr = 5'h00;
    logic [7:0] stat_wdata = 8'h00;
    wire logic  scl_oe, sda_oe, scl_low, sda_low, cfg_we;
    wire logic [7:0] cfg_addr, cfg_wdata;
    wire logic  scl = !(scl_oe || scl_low);
    wire logic  sda = !(sda_oe || sda_low);
    logic [7:0] mem [32];
    logic [7:0] qa[$], qd[$], d[3], p, v;
    logic       a;
    int         seed = 79606, bad_count = 0, num_checks = 0, cyc = 0;
    always #5 clk = !clk;
    initial #7 forever #32 lclk = !lclk;
    isrp_top uut (.CLK(clk), .NRST(nrst), .LCLK(lclk), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
        .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .STAT_WE(stat_we), .STAT_ADDR(stat_addr),
        .STAT_WDATA(stat_wdata), .CFG_WE(cfg_we), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata));
    isrp_host_mdl host (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
    // record host writes seen by the core; cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cfg_we === 1'b1) begin
            qa.push_back(cfg_addr);
            qd.push_back(cfg_wdata);
        end
        if (cyc == 90000) begin
            bad_count++;
            test_done();
        end
    end
    function automatic logic [7:0] exp_rd(input logic [7:0] ptr);
        return mem[ptr[4:0]];
    endfunction : exp_rd
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic stat_wr(input logic [4:0] ad, input logic [7:0] dt);
        @(negedge clk);
        stat_we = 1'b1;
        stat_addr = ad;
        stat_wdata = dt;
        @(negedge clk);
        stat_we = 1'b0;
        mem[ad] = dt;
    endtask : stat_wr
    // pointer then three data bytes, each expected as one core write
    task automatic wr_seq(input logic spk);
        host.start();
        host.wbyte({I2C_SLV_ADDR, 1'b0}, 1'b0, a);
        `CHK("addr ack", 1'b0, a)
        host.wbyte(p, 1'b0, a);
        for (int j = 0; j < 3; j++) begin
            host.wbyte(d[j], spk, a);
            `CHK("data ack", 1'b0, a)
        end
        host.stop();
        repeat (20) @(negedge clk);
        `CHK("write count", 3, qa.size())
        for (int j = 0; j < 3; j++) begin
            v = qa.pop_front();
            `CHK("cfg addr", p + 8'(j), v)
            v = qd.pop_front();
            `CHK("cfg data", d[j], v)
            mem[5'(p + 8'(j))] = d[j];
        end
        $display("test write at %h done", p);
    endtask : wr_seq
    // optional pointer write, then n bytes read, the last one refused
    task automatic rd_seq(input logic setp, input int n);
        if (setp) begin
            host.start();
            host.wbyte({I2C_SLV_ADDR, 1'b0}, 1'b0, a);
            host.wbyte(p, 1'b0, a);
        end
        host.start();
        host.wbyte({I2C_SLV_ADDR, 1'b1}, 1'b0, a);
        `CHK("rd addr ack", 1'b0, a)
        for (int j = 0; j < n; j++) begin
            host.rbyte(j == n - 1, v);
            `CHK("rd data", exp_rd(p + 8'(j)), v)
        end
        host.stop();
        p = p + 8'(n);
        $display("test read of %0d done", n);
    endtask : rd_seq
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (50) @(negedge clk);
        for (int i = 0; i < 32; i++)
            stat_wr(5'(i), 8'($random(seed)));
        for (int it = 0; it < 3; it++) begin
            // bare read goes first so p still holds the pointer the port has
            if (it == 2) begin
                rd_seq(1'b0, 1);
                host.start();
                host.wbyte({~I2C_SLV_ADDR, 1'b0}, 1'b0, a);
                host.stop();
                `CHK("foreign ack", 1'b1, a)
            end
            p = (it == 0) ? 8'h1E : 8'($random(seed)) & 8'h1F;
            for (int j = 0; j < 3; j++)
                d[j] = 8'($random(seed));
            wr_seq(it == 2);
            if (it < 2)
                rd_seq(1'b1, 3);
        end
        test_done();
    end
endmodule : tb
